// File: logic/asrr_cmp.v
`timescale 1ns/1ns
`default_nettype none
`include "asrr_map.vh"

module asrr_cmp (
  input wire [11:0] result_i,
  input wire [11:0] low_i,
  input wire [11:0] high_i,
  input wire prev_seen_i,
  input wire prev_above_i,
  output reg [1:0] range_o,
  output reg [1:0] cross_o,
  output wire above_o
);

  // Equal to the low threshold counts as above, matching the in-range test
  assign above_o = (result_i >= low_i);

  always @* begin
    if (result_i < low_i) begin
      range_o = `ASRR_RANGE_BELOW;
    end else if (result_i > high_i) begin
      range_o = `ASRR_RANGE_ABOVE;
    end else begin
      range_o = `ASRR_RANGE_IN;
    end
  end

  // Only the low threshold matters; first sample on a channel is no crossing
  always @* begin
    if (!prev_seen_i || (prev_above_i == above_o)) begin
      cross_o = `ASRR_CROSS_NONE;
    end else if (prev_above_i) begin
      cross_o = `ASRR_CROSS_DOWN;
    end else begin
      cross_o = `ASRR_CROSS_UP;
    end
  end

endmodule
`default_nettype wire

// File: logic/asrr_map.vh
`ifndef ASRR_MAP_VH
`define ASRR_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ASRR_ADDR_RESULT 32'h4001c014
`define ASRR_ADDR_CTRL 32'h4001c100
`define ASRR_ADDR_THR 32'h4001c104
`define ASRR_ADDR_STAT 32'h4001c108
`define ASRR_ADDR_MASK 32'h4001c10c

// ****************************************************************
// Result register fields
// ****************************************************************
`define ASRR_RES_LSB 4
`define ASRR_RES_MSB 15
`define ASRR_RANGE_LSB 16
`define ASRR_RANGE_MSB 17
`define ASRR_CROSS_LSB 18
`define ASRR_CROSS_MSB 19
`define ASRR_CHAN_LSB 26
`define ASRR_CHAN_MSB 29
`define ASRR_OVR_BIT 30
`define ASRR_VALID_BIT 31

// ****************************************************************
// Control and threshold fields
// ****************************************************************
`define ASRR_CTRL_MODE_BIT 0
`define ASRR_CTRL_CCIE_BIT 1
`define ASRR_CTRL_OVIE_BIT 2
`define ASRR_THR_LOW_LSB 0
`define ASRR_THR_LOW_MSB 11
`define ASRR_THR_HIGH_LSB 16
`define ASRR_THR_HIGH_MSB 27

// ****************************************************************
// Status and mask bits
// ****************************************************************
`define ASRR_EV_DONE_BIT 0
`define ASRR_EV_OVR_BIT 1

// ****************************************************************
// Reset values
// ****************************************************************
`define ASRR_CTRL_RST 3'h0
`define ASRR_THR_LOW_RST 12'h000
`define ASRR_THR_HIGH_RST 12'hfff
`define ASRR_MASK_RST 2'h0

// ****************************************************************
// Codes
// ****************************************************************
`define ASRR_RANGE_IN 2'h0
`define ASRR_RANGE_BELOW 2'h1
`define ASRR_RANGE_ABOVE 2'h2
`define ASRR_CROSS_NONE 2'h0
`define ASRR_CROSS_DOWN 2'h2
`define ASRR_CROSS_UP 2'h3
`define ASRR_NUM_CHAN 16

`endif

// File: logic/asrr_top.v
// How it works
// - range code 0 in, 1 below, 2 above
// - crossing judged only against low threshold
// - same side as before gives code 0
// - above then below gives code 2
// - below then above gives code 3
// - channel number in bits 29:26, binary
// - overrun set when loading over unread result
// - reading result clears overrun and valid
// - overrun requests interrupt in mode 0, enabled
// - valid set when new result loads
// - reading result clears valid bit
// - valid requests done interrupt in mode 0
// - twelve-bit result held in bits 15:4
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "asrr_map.vh"

module asrr_top (
  input wire clock_i,
  input wire rst_b_i,
  // Converter side, same clock domain
  input wire conv_done_i,
  input wire [11:0] conv_result_i,
  input wire [3:0] conv_chan_i,
  // Avalon-MM slave
  input wire [31:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // Interrupts
  output reg done_req_o,
  output reg ovr_req_o,
  output reg irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg [11:0] res_r;
  reg [1:0] range_r;
  reg [1:0] cross_r;
  reg [3:0] chan_r;
  reg ovr_r;
  reg valid_r;
  reg [2:0] ctrl_r;
  reg [11:0] thr_low_r;
  reg [11:0] thr_high_r;
  reg [1:0] stat_r;
  reg [1:0] mask_r;
  reg [`ASRR_NUM_CHAN-1:0] above_r;
  reg [`ASRR_NUM_CHAN-1:0] seen_r;

  reg ovr_nxt;
  reg valid_nxt;
  reg [1:0] stat_nxt;
  reg [31:0] rdata_nxt;

  wire [1:0] range_w;
  wire [1:0] cross_w;
  wire above_w;
  wire req_w;
  wire accept_w;
  wire commit_w;
  wire rd_clear_w;
  wire wr_commit_w;
  wire hit_result_w;
  wire eoc_mode_w;
  wire [31:0] result_word_w;
  wire [31:0] wmask_w;

  // ****************************************************************
  // Threshold compare
  // ****************************************************************
  asrr_cmp u_cmp (
    .result_i(conv_result_i),
    .low_i(thr_low_r),
    .high_i(thr_high_r),
    .prev_seen_i(seen_r[conv_chan_i]),
    .prev_above_i(above_r[conv_chan_i]),
    .range_o(range_w),
    .cross_o(cross_w),
    .above_o(above_w)
  );

  // ****************************************************************
  // Per-channel side records
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `ASRR_NUM_CHAN; g = g + 1) begin : g_chan
      localparam [3:0] CHAN_ID = g;
      // Records survive a threshold rewrite; next crossing uses the old side
      always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          above_r[g] <= 1'b0;
          seen_r[g] <= 1'b0;
        end else if (conv_done_i && (conv_chan_i == CHAN_ID)) begin
          above_r[g] <= above_w;
          seen_r[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Waitrequest drops for one cycle; the read side effect and data
  // capture happen together at the accept edge so a result loaded
  // between capture and clear can never be lost.
  assign req_w = avs_read_i || avs_write_i;
  assign accept_w = req_w && avs_waitrequest_o;
  assign commit_w = req_w && !avs_waitrequest_o;
  assign hit_result_w = (avs_address_i == `ASRR_ADDR_RESULT);
  assign rd_clear_w = accept_w && avs_read_i && hit_result_w;
  assign wr_commit_w = commit_w && avs_write_i;

  assign wmask_w = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !accept_w;
    end
  end

  // ****************************************************************
  // Result register image
  // ****************************************************************
  // Reserved spans always read as zero
  assign result_word_w = {
    valid_r,
    ovr_r,
    chan_r,
    6'h00,
    cross_r,
    range_r,
    res_r,
    4'h0
  };

  always @* begin
    case (avs_address_i)
      `ASRR_ADDR_RESULT: begin
        rdata_nxt = result_word_w;
      end
      `ASRR_ADDR_CTRL: begin
        rdata_nxt = {29'h0000000, ctrl_r};
      end
      `ASRR_ADDR_THR: begin
        rdata_nxt = {4'h0, thr_high_r, 4'h0, thr_low_r};
      end
      `ASRR_ADDR_STAT: begin
        rdata_nxt = {30'h0, stat_r};
      end
      `ASRR_ADDR_MASK: begin
        rdata_nxt = {30'h0, mask_r};
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (accept_w && avs_read_i) begin
      avs_readdata_o <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Result capture
  // ****************************************************************
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_r <= 12'h000;
      range_r <= `ASRR_RANGE_IN;
      cross_r <= `ASRR_CROSS_NONE;
      chan_r <= 4'h0;
    end else if (conv_done_i) begin
      res_r <= conv_result_i;
      range_r <= range_w;
      cross_r <= cross_w;
      chan_r <= conv_chan_i;
    end
  end

  // ****************************************************************
  // Valid and overrun flags
  // ****************************************************************
  // A load in the clearing cycle wins: the fresh result stays valid,
  // and it is not an overrun since the old one was just read.
  always @* begin
    valid_nxt = valid_r;
    ovr_nxt = ovr_r;
    if (rd_clear_w) begin
      valid_nxt = 1'b0;
      ovr_nxt = 1'b0;
    end
    if (conv_done_i) begin
      valid_nxt = 1'b1;
      if (valid_r && !rd_clear_w) begin
        ovr_nxt = 1'b1;
      end
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  // ****************************************************************
  // Control, thresholds, mask
  // ****************************************************************
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= `ASRR_CTRL_RST;
      thr_low_r <= `ASRR_THR_LOW_RST;
      thr_high_r <= `ASRR_THR_HIGH_RST;
      mask_r <= `ASRR_MASK_RST;
    end else if (wr_commit_w) begin
      case (avs_address_i)
        `ASRR_ADDR_CTRL: begin
          if (avs_byteenable_i[0]) begin
            ctrl_r <= avs_writedata_i[2:0];
          end
        end
        `ASRR_ADDR_THR: begin
          thr_low_r <= (thr_low_r & ~wmask_w[11:0]) | (avs_writedata_i[11:0] & wmask_w[11:0]);
          thr_high_r <= (thr_high_r & ~wmask_w[27:16]) |
                        (avs_writedata_i[27:16] & wmask_w[27:16]);
        end
        `ASRR_ADDR_MASK: begin
          if (avs_byteenable_i[0]) begin
            mask_r <= avs_writedata_i[1:0];
          end
        end
        default: begin
          mask_r <= mask_r;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sticky status, write one to clear
  // ****************************************************************
  always @* begin
    stat_nxt = stat_r;
    if (wr_commit_w && (avs_address_i == `ASRR_ADDR_STAT) && avs_byteenable_i[0]) begin
      stat_nxt = stat_r & ~avs_writedata_i[1:0];
    end
    if (conv_done_i) begin
      stat_nxt[`ASRR_EV_DONE_BIT] = 1'b1;
    end
    if (conv_done_i && valid_r && !rd_clear_w) begin
      stat_nxt[`ASRR_EV_OVR_BIT] = 1'b1;
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_r <= 2'h0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ****************************************************************
  // Interrupt outputs
  // ****************************************************************
  // Requests update on the same edge as the flags, from their next-state values.
  assign eoc_mode_w = !ctrl_r[`ASRR_CTRL_MODE_BIT];

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_req_o <= 1'b0;
      ovr_req_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      done_req_o <= valid_nxt && eoc_mode_w &&
                    ctrl_r[`ASRR_CTRL_CCIE_BIT];
      ovr_req_o <= ovr_nxt && eoc_mode_w &&
                   ctrl_r[`ASRR_CTRL_OVIE_BIT];
      irq_o <= |(stat_nxt & mask_r);
    end
  end

endmodule
`default_nettype wire

// File: tb/asrr_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "asrr_map.vh"
module asrr_checker (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic conv_done_i,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic done_req_o,
  input wire logic ovr_req_o,
  input wire logic irq_o
);
  // ****
  // Control mirror, so gating can be judged
  // ****
  logic [2:0] ctrl_r;
  wire rd_acc = avs_read_i && avs_waitrequest_o;
  wire rd_res = rd_acc && avs_address_i == `ASRR_ADDR_RESULT;
  wire wr_ctl = avs_write_i && !avs_waitrequest_o && avs_address_i == `ASRR_ADDR_CTRL
    && avs_byteenable_i[0];
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) ctrl_r <= 3'h0;
    else if (wr_ctl) ctrl_r <= avs_writedata_i[2:0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("no answer one cycle after accept");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  data_hold_a: assert property (!rd_acc |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  range_code_a: assert property (rd_res |=> avs_readdata_o[17:16] != 2'h3)
    else $error("reserved range code read");
  cross_code_a: assert property (rd_res |=> avs_readdata_o[19:18] != 2'h1)
    else $error("reserved crossing code read");
  valid_set_a: assert property (conv_done_i && ctrl_r[1:0] == 2'h2
    && !wr_ctl |=> done_req_o) else $error("done request missing after load");
  ovr_set_a: assert property (conv_done_i && done_req_o && !rd_res
    && !ctrl_r[0] && ctrl_r[2] && !wr_ctl |=> ovr_req_o)
    else $error("overrun request missing");
  read_clr_a: assert property (rd_res && !conv_done_i |=> !done_req_o && !ovr_req_o)
    else $error("flags not cleared by read");
  mode_gate_a: assert property (ctrl_r[0] && $past(ctrl_r[0])
    |-> !done_req_o && !ovr_req_o) else $error("request raised in sequence-end mode");
  cover property (rd_res && done_req_o);
  cover property (conv_done_i && ovr_req_o);
  cover property (irq_o && ctrl_r[0]);
endmodule
bind asrr_top asrr_checker u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .conv_done_i(conv_done_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .done_req_o(done_req_o), .ovr_req_o(ovr_req_o),
  .irq_o(irq_o));
`default_nettype wire

// File: tb/asrr_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "asrr_map.vh"
module asrr_top_bench;
  logic clock_i, rst_b_i, cd, rd, wr, dq, oq, iq, wq, vld;
  logic [11:0] res, low, high, v;
  logic [3:0] ch;
  logic [31:0] addr, wdat, rq, q, ex;
  logic [15:0] lf, seen, side;
  int fails, n_checks, cyc;
  asrr_top u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .conv_done_i(cd),
    .conv_result_i(res), .conv_chan_i(ch), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rq), .avs_waitrequest_o(wq), .done_req_o(dq), .ovr_req_o(oq),
    .irq_o(iq));
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // ****
  // Master holds the request until waitrequest is sampled low
  // ****
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= d;
    // Ends when waitrequest is sampled low; the bench timeout catches a hang
    do begin
      @(posedge clock_i);
    end while (wq !== 1'h0);
    q = rq;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  function automatic [1:0] exp_range(input logic [11:0] r);
    if (r < low) exp_range = 2'h1;
    else if (r > high) exp_range = 2'h2;
    else exp_range = 2'h0;
  endfunction
  // Crossing is judged against the low threshold only
  function automatic [1:0] exp_cross(input logic known, input logic prev_up,
                                     input logic now_up);
    if (!known || prev_up == now_up) exp_cross = 2'h0;
    else if (prev_up) exp_cross = 2'h2;
    else exp_cross = 2'h3;
  endfunction
  task conv(input logic [3:0] cc, input logic [11:0] vv);
    logic a;
    a = vv >= low;
    @(posedge clock_i);
    cd <= 1'h1;
    ch <= cc;
    res <= vv;
    @(posedge clock_i);
    cd <= 1'h0;
    ex = {1'h1, vld, cc, 6'h0, exp_cross(seen[cc], side[cc], a), exp_range(vv), vv, 4'h0};
    vld = 1'h1;
    seen[cc] = 1'h1;
    side[cc] = a;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      stop_test;
    end
  end
  initial begin
    cd = 1'h0;
    rd = 1'h0;
    wr = 1'h0;
    addr = 32'h0;
    wdat = 32'h0;
    ch = 4'h0;
    res = 12'h0;
    seen = 16'h0;
    side = 16'h0;
    vld = 1'h0;
    lf = 16'd34441;
    rst_b_i = 1'h0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'h1;
    bus(1'h0, `ASRR_ADDR_RESULT, 32'h0);
    chk("reset_flags", q[31:30], 2'h0);
    bus(1'h0, 32'h4001c200, 32'h0);
    chk("unmapped", q, 32'h0);
    lf = nx(lf);
    low = {1'h0, lf[10:0]};
    high = low + {2'h0, lf[15:6]};
    bus(1'h1, `ASRR_ADDR_THR, {4'h0, high, 4'h0, low});
    bus(1'h0, `ASRR_ADDR_THR, 32'h0);
    chk("thr_readback", q, {4'h0, high, 4'h0, low});
    bus(1'h1, `ASRR_ADDR_CTRL, 32'h6);
    bus(1'h1, `ASRR_ADDR_MASK, 32'h3);
    bus(1'h0, `ASRR_ADDR_CTRL, 32'h0);
    chk("ctrl_readback", q, 32'h6);
    repeat (60) begin
      lf = nx(lf);
      case (lf[1:0])
        2'h0: v = low;
        2'h1: v = low - 12'h1;
        2'h2: v = high + 12'h1;
        default: v = lf[15:4];
      endcase
      conv(lf[5:2], v);
      // Second load before the read forces an overrun
      if (lf[6]) begin
        conv(lf[10:7], high);
      end
      @(negedge clock_i);
      chk("done_req", dq, 1'h1);
      chk("ovr_req", oq, ex[30]);
      chk("irq", iq, 1'h1);
      bus(1'h0, `ASRR_ADDR_STAT, 32'h0);
      chk("status", q, {30'h0, ex[30], 1'h1});
      bus(1'h0, `ASRR_ADDR_RESULT, 32'h0);
      chk("result", q & 32'hfc0ffff0, ex);
      vld = 1'h0;
      @(negedge clock_i);
      chk("read_clear", {dq, oq}, 2'h0);
      bus(1'h1, `ASRR_ADDR_STAT, 32'h3);
      @(negedge clock_i);
      chk("irq_clear", iq, 1'h0);
    end
    bus(1'h1, `ASRR_ADDR_CTRL, 32'h7);
    conv(4'h1, low);
    @(negedge clock_i);
    chk("mode1_req", {dq, oq}, 2'h0);
    bus(1'h1, `ASRR_ADDR_CTRL, 32'h2);
    bus(1'h1, `ASRR_ADDR_MASK, 32'h0);
    conv(4'h2, high);
    @(negedge clock_i);
    chk("no_ovie", {dq, oq, iq}, 3'h4);
    stop_test;
  end
endmodule
`default_nettype wire
